// File: rtl/sck_byte_sender.sv
// Purpose: sends a left-justified message byte by byte with valid/ready
// Assumes: start only while busy is low
// Notes: first byte is taken from the top of msg
module sck_byte_sender import sck_pkg::*; #(
	parameter int MAXB = MSG_BYTES
) (
	input wire logic core_clk,
	input wire logic clear,
	input wire logic start,
	input wire logic [7:0] count,
	input wire logic [MAXB*8-1:0] msg,
	output logic txValid,
	output logic [7:0] txByte,
	input wire logic txReady,
	output logic busy
);
	if (MAXB < MSG_BYTES) begin : g_chk
		$error("sender too small for the notice");
	end
	logic [MAXB*8-1:0] shift_r;
	logic [7:0] left_r;
	assign txByte = shift_r[MAXB*8-1 -: 8];
	always_ff @(posedge core_clk) begin
		if (clear) begin
			shift_r <= '0;
			left_r <= '0;
			txValid <= 1'b0;
			busy <= 1'b0;
		end else if (start && !busy) begin
			shift_r <= msg;
			left_r <= count;
			txValid <= (count != 8'h00);
			busy <= (count != 8'h00);
		end else if (txValid && txReady) begin
			shift_r <= {shift_r[MAXB*8-9:0], 8'h00};
			left_r <= left_r - 8'h01;
			txValid <= (left_r != CNT_ONE);
			busy <= (left_r != CNT_ONE);
		end
	end
endmodule

// File: rtl/sck_command_unit.sv
// Purpose: special command register, key stores and security/pairing status
// Assumes: rx/tx bytes come from a serial engine on core_clk; pbPin is a pin
// Notes: rstn stands for power-up; factory defaults end in an internal reset
// Contract
// - command register is write only and triggers operations, stores nothing
// - codes 10,11,12,13; code 20 needs guard bytes aa bb
// - pairing subcommand 0 halts, 1 generates key, 2 starts pairing
// - subcommand 1 generates key, clears key receive flag, becomes admin
// - serially started pairing makes pushbutton ignored until it ends
// - during pairing all writes refused except halt
// - halt completes before its acknowledge is sent
// - key receive flag at start picks admin or node role
// - successful pairing copies changed persistent registers to volatile ones
// - key write carries select and sixteen key bytes, all stored
// - select 01 is runtime key store, 02 is persistent store
// - power-up loads runtime key from persistent key; runtime key volatile; rstn clears both key stores, the load only follows the internal reset
// - all-zero key means no key
// - key zeroize frame size 04, code 12, select; clears chosen store
// - key restore copies persistent key into runtime key
// - factory defaults restores every persistent register to default
// - after defaults send notice line then reset as on power-up
// - security state read answers ack, address, one value byte
// - security bit 1 runtime key present, bit 2 persistent key present
// - pairing state read returns current or last pairing state
// - refused write raises write refused flag
// - pairing start raises pairing started flag
module sck_command_unit import sck_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic rxValid,
	input wire logic [7:0] rxByte,
	output logic rxReady,
	output logic txValid,
	output logic [7:0] txByte,
	input wire logic txReady,
	input wire logic pbPin,
	input wire sck_join_stat_t joinStat,
	output sck_join_req_t joinReq,
	output logic keyRecvFlag,
	output logic nvToVolCopy,
	output logic writeRefused,
	output logic pairingStarted,
	output logic factoryDefaults,
	output logic selfReset,
	output logic [KEY_BYTES*8-1:0] runtimeKey
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	sck_state_t st_r;
	sck_state_t st_nxt;
	logic softRst_r;
	logic ctlRst;
	logic [7:0] size_r;
	logic [7:0] cnt_r;
	logic [7:0] decN_r;
	logic [7:0] addr_r;
	logic [7:0] op_r;
	logic [7:0] arg_r;
	logic [7:0] guard_r;
	logic escPend_r;
	logic isRead_r;
	logic [7:0] keyBuf [KEY_BYTES];
	logic [7:0] rtKey [KEY_BYTES];
	logic [7:0] nvKey [KEY_BYTES];
	logic rxFire;
	logic newEsc;
	logic readMark;
	logic decValid;
	logic [7:0] decByte;
	logic isCmd;
	logic readOurs;
	logic haltOp;
	logic opOk;
	logic refuse;
	logic doOp;
	logic defsOp;
	logic rtAny;
	logic nvAny;
	logic [7:0] secVal;
	logic [7:0] pstVal_r;
	logic serialJoin_r;
	logic pbMeta_r;
	logic pbSync_r;
	logic pbPrev_r;
	logic pbStart;
	logic serStart;
	logic haltDone;
	logic txStart_r;
	logic [7:0] txCnt_r;
	logic [MSG_BYTES*8-1:0] txMsg_r;
	logic txBusy;
	logic rxReady_r;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic selOk(input logic [7:0] sel);
		return (sel == SEL_RT) || (sel == SEL_NV);
	endfunction
	function automatic logic [MSG_BYTES*8-1:0] oneByte(input logic [7:0] b);
		return {b, {((MSG_BYTES - 1) * 8){1'b0}}};
	endfunction
	assign ctlRst = !rstn || softRst_r;
	assign rxReady = rxReady_r;
	assign rxFire = rxValid && rxReady_r;
	// ----------------------------------------------------------------
	// escape decoding
	// ----------------------------------------------------------------
	assign newEsc = (rxByte == ESC_BYTE) && !escPend_r;
	assign readMark = (rxByte == ESC_BYTE) && escPend_r && (decN_r == IDX_ADDR) && !isRead_r;
	assign decValid = rxFire && (st_r == ST_BODY) && !newEsc && !readMark;
	assign decByte = escPend_r ? 8'(rxByte + ESC_ADD) : rxByte;
	// ----------------------------------------------------------------
	// frame decode
	// ----------------------------------------------------------------
	assign isCmd = !isRead_r && (addr_r == ADDR_CMD) && (decN_r > IDX_OP);
	assign readOurs = (isRead_r || decN_r == LEN_READ) && ((addr_r == ADDR_SEC) || (addr_r == ADDR_PST));
	assign haltOp = isCmd && (op_r == OP_PAIR) && (arg_r == SUB_HALT) && (decN_r == LEN_ARG);
	assign defsOp = isCmd && (op_r == OP_DEFS);
	always_comb begin
		opOk = 1'b0;
		case (op_r)
			OP_PAIR: opOk = (decN_r == LEN_ARG) && (arg_r <= SUB_JOIN);
			OP_KEYW: opOk = (decN_r == LEN_KEYW) && selOk(arg_r);
			OP_KEYZ: opOk = (decN_r == LEN_ARG) && selOk(arg_r);
			OP_KEYR: opOk = (decN_r == LEN_KEYR);
			OP_DEFS: opOk = (decN_r == LEN_DEFS) && (arg_r == GUARD_A) && (guard_r == GUARD_B);
			default: opOk = 1'b0;
		endcase
	end
	// writes other than halt are refused while pairing runs
	assign refuse = !(isRead_r || decN_r == LEN_READ) && (addr_r == ADDR_CMD || joinStat.active)
		&& ((joinStat.active && !haltOp) || (isCmd && !opOk) || (addr_r == ADDR_CMD && !isCmd));
	assign doOp = (st_r == ST_EXEC) && isCmd && !refuse;
	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_HEAD: st_nxt = ST_HEAD;
			ST_SIZE: begin
				if (rxFire) begin
					st_nxt = (rxByte == 8'h00) ? ST_HEAD : ST_BODY;
				end
			end
			ST_BODY: begin
				if (rxFire && (8'(cnt_r + 8'h01) == size_r)) begin
					st_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (refuse || readOurs) begin
					st_nxt = ST_TXW;
				end else if (haltOp) begin
					st_nxt = ST_HALT;
				end else if (defsOp) begin
					st_nxt = ST_RSTW;
				end else if (isCmd) begin
					st_nxt = ST_TXW;
				end else begin
					st_nxt = ST_HEAD;
				end
			end
			ST_HALT: begin
				if (!joinStat.active) begin
					st_nxt = ST_TXW;
				end
			end
			ST_TXW: begin
				if (!txBusy && !txStart_r) begin
					st_nxt = ST_HEAD;
				end
			end
			ST_RSTW: st_nxt = ST_RSTW;
		endcase
		if (rxFire && (rxByte == HDR_BYTE)) begin
			st_nxt = ST_SIZE;
		end
	end
	always_ff @(posedge core_clk) begin
		if (ctlRst) begin
			st_r <= ST_HEAD;
			rxReady_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			rxReady_r <= (st_nxt == ST_HEAD) || (st_nxt == ST_SIZE) || (st_nxt == ST_BODY);
		end
	end
	// internal reset once the notice has left
	always_ff @(posedge core_clk) begin
		if (!rstn || softRst_r) begin
			softRst_r <= 1'b0;
		end else begin
			softRst_r <= (st_r == ST_RSTW) && !txBusy && !txStart_r;
		end
	end
	// ----------------------------------------------------------------
	// frame capture
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (ctlRst) begin
			size_r <= '0;
			cnt_r <= '0;
			decN_r <= '0;
			addr_r <= '0;
			op_r <= '0;
			arg_r <= '0;
			guard_r <= '0;
			escPend_r <= 1'b0;
			isRead_r <= 1'b0;
		end else if (rxFire && (rxByte == HDR_BYTE)) begin
			cnt_r <= '0;
			decN_r <= '0;
			escPend_r <= 1'b0;
			isRead_r <= 1'b0;
		end else if (rxFire && (st_r == ST_SIZE)) begin
			size_r <= rxByte;
		end else if (rxFire && (st_r == ST_BODY)) begin
			cnt_r <= 8'(cnt_r + 8'h01);
			if (readMark) begin
				isRead_r <= 1'b1;
			end else if (newEsc) begin
				escPend_r <= 1'b1;
			end else begin
				escPend_r <= 1'b0;
				decN_r <= 8'(decN_r + 8'h01);
				if (decN_r == IDX_ADDR) begin
					addr_r <= decByte;
				end
				if (decN_r == IDX_OP) begin
					op_r <= decByte;
				end
				if (decN_r == IDX_ARG) begin
					arg_r <= decByte;
				end
				if (decN_r == IDX_KEY0) begin
					guard_r <= decByte;
				end
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (decValid && (decN_r >= IDX_KEY0) && (decN_r < LEN_KEYW)) begin
			keyBuf[4'(decN_r - IDX_KEY0)] <= decByte;
		end
	end
	// ----------------------------------------------------------------
	// key stores
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int i = 0; i < KEY_BYTES; i++) begin
				rtKey[i] <= '0;
				nvKey[i] <= '0;
			end
		end else if (softRst_r) begin
			for (int i = 0; i < KEY_BYTES; i++) begin
				rtKey[i] <= nvKey[i];
			end
		end else if (doOp) begin
			for (int i = 0; i < KEY_BYTES; i++) begin
				if (op_r == OP_KEYW && arg_r == SEL_RT) begin
					rtKey[i] <= keyBuf[i];
				end
				if (op_r == OP_KEYW && arg_r == SEL_NV) begin
					nvKey[i] <= keyBuf[i];
				end
				if (op_r == OP_KEYZ && arg_r == SEL_RT) begin
					rtKey[i] <= '0;
				end
				if (op_r == OP_KEYZ && arg_r == SEL_NV) begin
					nvKey[i] <= '0;
				end
				if (op_r == OP_KEYR) begin
					rtKey[i] <= nvKey[i];
				end
				if (op_r == OP_DEFS) begin
					nvKey[i] <= '0;
				end
			end
		end
	end
	always_comb begin
		rtAny = 1'b0;
		nvAny = 1'b0;
		for (int i = 0; i < KEY_BYTES; i++) begin
			rtAny = rtAny | (|rtKey[i]);
			nvAny = nvAny | (|nvKey[i]);
		end
		secVal = '0;
		secVal[SEC_RT_BIT] = rtAny;
		secVal[SEC_NV_BIT] = nvAny;
	end
	for (genvar g = 0; g < KEY_BYTES; g++) begin : g_key
		assign runtimeKey[(KEY_BYTES - 1 - g) * 8 +: 8] = rtKey[g];
	end
	// ----------------------------------------------------------------
	// pushbutton
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (ctlRst) begin
			pbMeta_r <= 1'b0;
			pbSync_r <= 1'b0;
			pbPrev_r <= 1'b0;
		end else begin
			pbMeta_r <= pbPin;
			pbSync_r <= pbMeta_r;
			pbPrev_r <= pbSync_r;
		end
	end
	assign pbStart = pbSync_r && !pbPrev_r && !serialJoin_r && !joinStat.active;
	assign serStart = doOp && (op_r == OP_PAIR) && (arg_r == SUB_JOIN);
	assign haltDone = (st_r == ST_HALT) && !joinStat.active;
	// ----------------------------------------------------------------
	// pairing control
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (ctlRst) begin
			joinReq <= '0;
			serialJoin_r <= 1'b0;
			pstVal_r <= PST_IDLE;
			nvToVolCopy <= 1'b0;
			pairingStarted <= 1'b0;
		end else begin
			joinReq.start <= serStart || pbStart;
			joinReq.halt <= (st_r == ST_EXEC) && haltOp;
			joinReq.genKey <= doOp && (op_r == OP_PAIR) && (arg_r == SUB_GENKEY);
			pairingStarted <= serStart || pbStart;
			nvToVolCopy <= joinStat.finished && joinStat.success;
			if (serStart || pbStart) begin
				joinReq.asAdmin <= !keyRecvFlag;
				pstVal_r <= PST_BUSY;
			end else if (joinStat.finished) begin
				pstVal_r <= joinStat.success ? PST_DONE : PST_FAILED;
			end else if (haltDone && (pstVal_r == PST_BUSY)) begin
				pstVal_r <= PST_HALTED;
			end
			if (serStart) begin
				serialJoin_r <= 1'b1;
			end else if (joinStat.finished || haltDone) begin
				serialJoin_r <= 1'b0;
			end
		end
	end
	// key receive flag is persistent: only power-up and defaults restore it
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			keyRecvFlag <= KEY_RECEIVE_FLAG_DEFAULT;
		end else if (doOp && (op_r == OP_PAIR) && (arg_r == SUB_GENKEY)) begin
			keyRecvFlag <= 1'b0;
		end else if (doOp && (op_r == OP_DEFS)) begin
			keyRecvFlag <= KEY_RECEIVE_FLAG_DEFAULT;
		end
	end
	// ----------------------------------------------------------------
	// event pulses
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (ctlRst) begin
			writeRefused <= 1'b0;
			factoryDefaults <= 1'b0;
			selfReset <= 1'b0;
		end else begin
			writeRefused <= (st_r == ST_EXEC) && refuse;
			factoryDefaults <= doOp && (op_r == OP_DEFS);
			selfReset <= (st_r == ST_RSTW) && !txBusy && !txStart_r;
		end
	end
	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (ctlRst) begin
			txStart_r <= 1'b0;
			txCnt_r <= '0;
			txMsg_r <= '0;
		end else begin
			txStart_r <= 1'b0;
			if (st_r == ST_EXEC) begin
				if (refuse) begin
					txStart_r <= 1'b1;
					txCnt_r <= CNT_ONE;
					txMsg_r <= oneByte(ANS_NAK);
				end else if (readOurs) begin
					txStart_r <= 1'b1;
					txCnt_r <= CNT_READ;
					txMsg_r <= {ANS_ACK, addr_r, (addr_r == ADDR_SEC) ? secVal : pstVal_r,
						{((MSG_BYTES - 3) * 8){1'b0}}};
				end else if (defsOp) begin
					txStart_r <= 1'b1;
					txCnt_r <= CNT_NOTICE;
					txMsg_r <= NOTICE_MSG;
				end else if (isCmd && !haltOp) begin
					txStart_r <= 1'b1;
					txCnt_r <= CNT_ONE;
					txMsg_r <= oneByte(ANS_ACK);
				end
			end else if (haltDone) begin
				txStart_r <= 1'b1;
				txCnt_r <= CNT_ONE;
				txMsg_r <= oneByte(ANS_ACK);
			end
		end
	end
	sck_byte_sender #(
		.MAXB(MSG_BYTES)
	) u_sender (
		.core_clk(core_clk),
		.clear(ctlRst),
		.start(txStart_r),
		.count(txCnt_r),
		.msg(txMsg_r),
		.txValid(txValid),
		.txByte(txByte),
		.txReady(txReady),
		.busy(txBusy)
	);
endmodule

// File: rtl/sck_pkg.sv
// Purpose: shared constants and types of the special command and key unit
// Assumes: bytes arrive still framed (header, size, escapes) from the serial receiver
// Notes: addresses are the full decoded register addresses
package sck_pkg;
	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	localparam logic [7:0] HDR_BYTE = 8'hff;
	localparam logic [7:0] ESC_BYTE = 8'hfe;
	localparam logic [7:0] ESC_ADD = 8'h80;
	localparam logic [7:0] ANS_ACK = 8'h06;
	localparam logic [7:0] ANS_NAK = 8'h15;
	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'hc7;
	localparam logic [7:0] ADDR_SEC = 8'hc9;
	localparam logic [7:0] ADDR_PST = 8'hca;
	// ----------------------------------------------------------------
	// operation codes and operands
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_PAIR = 8'h10;
	localparam logic [7:0] OP_KEYW = 8'h11;
	localparam logic [7:0] OP_KEYZ = 8'h12;
	localparam logic [7:0] OP_KEYR = 8'h13;
	localparam logic [7:0] OP_DEFS = 8'h20;
	localparam logic [7:0] GUARD_A = 8'haa;
	localparam logic [7:0] GUARD_B = 8'hbb;
	localparam logic [7:0] SUB_HALT = 8'h00;
	localparam logic [7:0] SUB_GENKEY = 8'h01;
	localparam logic [7:0] SUB_JOIN = 8'h02;
	localparam logic [7:0] SEL_RT = 8'h01;
	localparam logic [7:0] SEL_NV = 8'h02;
	// ----------------------------------------------------------------
	// decoded byte positions and frame lengths
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_ADDR = 8'h00;
	localparam logic [7:0] IDX_OP = 8'h01;
	localparam logic [7:0] IDX_ARG = 8'h02;
	localparam logic [7:0] IDX_KEY0 = 8'h03;
	localparam logic [7:0] LEN_READ = 8'h01;
	localparam logic [7:0] LEN_KEYR = 8'h02;
	localparam logic [7:0] LEN_ARG = 8'h03;
	localparam logic [7:0] LEN_DEFS = 8'h04;
	localparam logic [7:0] LEN_KEYW = 8'h13;
	localparam int KEY_BYTES = 16;
	// ----------------------------------------------------------------
	// status values
	// ----------------------------------------------------------------
	localparam int SEC_RT_BIT = 1;
	localparam int SEC_NV_BIT = 2;
	localparam logic [7:0] PST_IDLE = 8'h00;
	localparam logic [7:0] PST_BUSY = 8'h01;
	localparam logic [7:0] PST_DONE = 8'h02;
	localparam logic [7:0] PST_HALTED = 8'h03;
	localparam logic [7:0] PST_FAILED = 8'h04;
	localparam logic KEY_RECEIVE_FLAG_DEFAULT = 1'b1;
	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	localparam int MSG_BYTES = 23;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] CNT_READ = 8'h03;
	localparam logic [7:0] CNT_NOTICE = 8'h17;
	localparam logic [MSG_BYTES*8-1:0] NOTICE_MSG = "\r\nConfiguration Reset\r\n";
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_HEAD = 7'b0000001,
		ST_SIZE = 7'b0000010,
		ST_BODY = 7'b0000100,
		ST_EXEC = 7'b0001000,
		ST_HALT = 7'b0010000,
		ST_TXW = 7'b0100000,
		ST_RSTW = 7'b1000000
	} sck_state_t;
	typedef struct packed {
		logic start;
		logic halt;
		logic genKey;
		logic asAdmin;
	} sck_join_req_t;
	typedef struct packed {
		logic active;
		logic finished;
		logic success;
	} sck_join_stat_t;
endpackage

// File: verification/sck_command_unit_checker.sv
// Purpose: concurrent checks on the special command unit ports
// Assumes: single clock domain, rstn synchronous active low
// Notes: attached by bind below
module sck_command_unit_checker import sck_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic rxReady,
	input wire logic txValid,
	input wire logic [7:0] txByte,
	input wire logic txReady,
	input wire sck_join_stat_t joinStat,
	input wire sck_join_req_t joinReq,
	input wire logic keyRecvFlag,
	input wire logic nvToVolCopy,
	input wire logic writeRefused,
	input wire logic pairingStarted,
	input wire logic selfReset
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_tx_hold_stable: assert property (txValid && !txReady |=> txValid && $stable(txByte))
		else $error("answer byte dropped or changed before taken");
	a_rx_quiet_tx: assert property (txValid |-> !rxReady)
		else $error("new bytes accepted while answering");
	a_halt_before_ack: assert property (joinReq.halt ##1 joinStat.active |-> !txValid)
		else $error("answer sent before pairing stopped");
	a_refuse_nak: assert property (writeRefused |-> ##[0:4] (txValid && txByte == ANS_NAK))
		else $error("refused write not answered with nak");
	a_genkey_admin: assert property (joinReq.genKey |-> ##[0:2] !keyRecvFlag)
		else $error("key generation left key receive flag set");
	a_start_flag: assert property (joinReq.start |-> pairingStarted)
		else $error("pairing start without started flag");
	a_role_latch: assert property (joinReq.start |-> joinReq.asAdmin == !$past(keyRecvFlag))
		else $error("role does not follow key receive flag");
	a_copy_success: assert property (joinStat.finished && joinStat.success |-> ##[1:3] nvToVolCopy)
		else $error("no register copy after successful pairing");
	a_halt_pulse: assert property (joinReq.halt |=> !joinReq.halt)
		else $error("halt request longer than one cycle");
	a_reset_quiet: assert property (selfReset |-> !txValid)
		else $error("self reset while answer pending");
endmodule
bind sck_command_unit sck_command_unit_checker sck_command_unit_checker_i (.core_clk, .rstn,
	.rxReady, .txValid, .txByte, .txReady, .joinStat, .joinReq, .keyRecvFlag, .nvToVolCopy,
	.writeRefused, .pairingStarted, .selfReset);

// File: verification/sck_host_model.sv
// Purpose: host side of the serial command link, byte sender and answer sink
// Assumes: bytes change on the falling edge, taken on rising edge with ready
// Notes: slow makes the sink stall every other cycle
module sck_host_model (
	input wire logic core_clk,
	input wire logic rxReady,
	input wire logic txValid,
	input wire logic [7:0] txByte,
	output logic rxValid,
	output logic [7:0] rxByte,
	output logic txReady
);
	timeunit 1ns;
	timeprecision 1ns;
	logic slow = 1'b0;
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h5a;
		txReady = 1'b1;
	end
	always @(negedge core_clk) txReady <= slow ? ~txReady : 1'b1;
	// request held until taken at a rising edge
	task automatic send(input logic [7:0] b);
		@(negedge core_clk);
		rxValid = 1'b1;
		rxByte = b;
		do @(posedge core_clk); while (rxReady !== 1'b1);
	endtask
	// released line shows a changing pattern, not the last byte
	task automatic rel();
		@(negedge core_clk);
		rxValid = 1'b0;
		rxByte = ~rxByte;
	endtask
	task automatic recv(output logic [7:0] b);
		do @(posedge core_clk); while (!(txValid === 1'b1 && txReady === 1'b1));
		b = txByte;
	endtask
endmodule

// File: verification/special_command_and_key_unit_tb_top.sv
// Purpose: self-checking bench of the special command unit
// Assumes: host model drives the byte link; bench plays the pairing engine
// Notes: key bytes are 01..10 to avoid escapes
module special_command_and_key_unit_tb_top;
	import sck_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [71:0] f;
		int n;
		bit k;
		logic [23:0] a;
		int na;
	} sck_row_t;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic rxValid, rxReady, txValid, txReady, pbPin, keyRecvFlag, nvToVolCopy;
	logic writeRefused, pairingStarted, factoryDefaults, selfReset;
	logic [7:0] rxByte, txByte, b;
	logic [127:0] runtimeKey;
	sck_join_stat_t joinStat;
	sck_join_req_t joinReq;
	int n_fail = 0;
	int checked = 0;
	int nStart = 0;
	int nRef = 0;
	int nCopy = 0;
	int nDefs = 0;
	int w;
	sck_row_t rows [13] = '{
		'{72'hff03fefe49, 5, 0, 24'h06c900, 3}, '{72'hff14fe471101, 6, 1, 24'h06, 1},
		'{72'hff03fefe49, 5, 0, 24'h06c902, 3}, '{72'hff14fe471102, 6, 1, 24'h06, 1},
		'{72'hff03fefe49, 5, 0, 24'h06c906, 3}, '{72'hff04fe471201, 6, 0, 24'h06, 1},
		'{72'hff03fefe49, 5, 0, 24'h06c904, 3}, '{72'hff03fe4713, 5, 0, 24'h06, 1},
		'{72'hff03fefe49, 5, 0, 24'h06c906, 3}, '{72'hff03fe4714, 5, 0, 24'h15, 1},
		'{72'hff04fe471203, 6, 0, 24'h15, 1}, '{72'hff03fefe4a, 5, 0, 24'h06ca00, 3},
		'{72'hff04fe471001, 6, 0, 24'h06, 1}};
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (joinReq.start === 1'b1) nStart <= nStart + 1;
		if (writeRefused === 1'b1) nRef <= nRef + 1;
		if (nvToVolCopy === 1'b1) nCopy <= nCopy + 1;
		if (factoryDefaults === 1'b1) nDefs <= nDefs + 1;
	end
	sck_command_unit sck_command_unit_i (.core_clk, .rstn, .rxValid, .rxByte, .rxReady,
		.txValid, .txByte, .txReady, .pbPin, .joinStat, .joinReq, .keyRecvFlag, .nvToVolCopy,
		.writeRefused, .pairingStarted, .factoryDefaults, .selfReset, .runtimeKey);
	sck_host_model sck_host_model_i (.core_clk, .rxReady, .txValid, .txByte, .rxValid, .rxByte,
		.txReady);
	task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic run(input sck_row_t r);
		for (int i = 0; i < r.n; i++) sck_host_model_i.send(r.f[8*(r.n-1-i) +: 8]);
		if (r.k) for (int i = 1; i <= KEY_BYTES; i++) sck_host_model_i.send(8'(i));
		sck_host_model_i.rel();
		for (int i = 0; i < r.na; i++) begin
			sck_host_model_i.recv(b);
			chk("answer", b, r.a[8*(r.na-1-i) +: 8]);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		pbPin = 1'b0;
		joinStat = '0;
		repeat (3) @(negedge core_clk);
		rstn = 1'b1;
		chk("key flag", keyRecvFlag, 1'b1);
		chk("runtime key", runtimeKey, '0);
		$display("reset test done");
		foreach (rows[i]) run(rows[i]);
		chk("runtime key", runtimeKey, 128'h0102030405060708090a0b0c0d0e0f10);
		chk("key flag", keyRecvFlag, 1'b0);
		$display("row tests done");
		// ----------------------------------------------------------------
		// refusal and halt while pairing runs, with a stalling sink
		// ----------------------------------------------------------------
		sck_host_model_i.slow = 1'b1;
		@(negedge core_clk) pbPin = 1'b1;
		repeat (6) @(negedge core_clk);
		pbPin = 1'b0;
		chk("start count", nStart, 1);
		chk("admin role", joinReq.asAdmin, 1'b1);
		joinStat.active = 1'b1;
		run('{72'hff04fe471202, 6, 0, 24'h15, 1});
		run('{72'hff04fe471000, 6, 0, 24'h0, 0});
		w = 0;
		while (joinReq.halt !== 1'b1 && w < 50) begin
			@(posedge core_clk);
			w++;
		end
		chk("halt req", w < 50, 1'b1);
		repeat (5) @(negedge core_clk);
		chk("halt wait", txValid, 1'b0);
		joinStat.active = 1'b0;
		sck_host_model_i.recv(b);
		chk("halt ack", b, ANS_ACK);
		run('{72'hff03fefe4a, 5, 0, 24'h06ca03, 3});
		$display("halt test done");
		// ----------------------------------------------------------------
		// serial start, pushbutton ignored, successful end
		// ----------------------------------------------------------------
		run('{72'hff04fe471002, 6, 0, 24'h06, 1});
		@(negedge core_clk) pbPin = 1'b1;
		repeat (8) @(negedge core_clk);
		pbPin = 1'b0;
		chk("start count", nStart, 2);
		joinStat.active = 1'b1;
		@(negedge core_clk) joinStat = '{active: 1'b0, finished: 1'b1, success: 1'b1};
		@(negedge core_clk) joinStat = '0;
		run('{72'hff03fefe4a, 5, 0, 24'h06ca02, 3});
		$display("pairing test done");
		// ----------------------------------------------------------------
		// factory defaults, notice line, self reset
		// ----------------------------------------------------------------
		run('{72'hff07fe4720fe2afe3b, 9, 0, 24'h0, 0});
		for (int i = 0; i < MSG_BYTES; i++) begin
			sck_host_model_i.recv(b);
			chk("notice", b, NOTICE_MSG[8*(MSG_BYTES-1-i) +: 8]);
		end
		repeat (6) @(negedge core_clk);
		chk("key flag", keyRecvFlag, KEY_RECEIVE_FLAG_DEFAULT);
		chk("runtime key", runtimeKey, '0);
		run('{72'hff03fefe4a, 5, 0, 24'h06ca00, 3});
		chk("refused", nRef, 3);
		chk("copies", nCopy, 1);
		chk("defaults", nDefs, 1);
		$display("defaults test done");
		tally_and_finish();
	end
endmodule
